// ==== inc/dpmu_defines.svh ====
/*
 * Constants of the upper DSCP priority map bank: register offsets,
 * field positions, reset values, code range and read timing.
 * Assumes it is included by bare name from design files and the testbench.
 */
`ifndef DPMU_DEFINES_SVH
`define DPMU_DEFINES_SVH

// register offsets, byte addresses on the register port
`define DPMU_OFS_2C_2D  16'h0350
`define DPMU_OFS_22_23  16'h0351
`define DPMU_OFS_24_25  16'h0352
`define DPMU_OFS_26_27  16'h0353
`define DPMU_OFS_28_29  16'h0354
`define DPMU_OFS_2A_2B  16'h0355
`define DPMU_OFS_2E_2F  16'h0357
`define DPMU_OFS_30_31  16'h0358
`define DPMU_OFS_32_33  16'h0359
`define DPMU_OFS_34_35  16'h035a
`define DPMU_OFS_36_37  16'h035b
`define DPMU_OFS_38_39  16'h035c

// bank geometry
`define DPMU_NREG       12
`define DPMU_ADDR_W     16
`define DPMU_DATA_W     8
`define DPMU_DSCP_W     6
`define DPMU_PRIO_W     3

// field positions inside one mapping register
`define DPMU_HI_MSB     6
`define DPMU_HI_LSB     4
`define DPMU_RSV_HI     7
`define DPMU_LO_MSB     2
`define DPMU_LO_LSB     0
`define DPMU_RSV_LO     3

// reset values
`define DPMU_PRIO_RST   3'h0
`define DPMU_RSV_VAL    1'b0
`define DPMU_RDATA_RST  8'h00

// dscp codes served by this bank
`define DPMU_CODE_FIRST 6'h22
`define DPMU_CODE_LAST  6'h39

// cycles from strobe to read data, and from lookup to result
`define DPMU_RD_LAT     1
`define DPMU_LK_LAT     1

`endif

// ==== inc/dpmu_pkg.sv ====
/*
 * Types of the upper DSCP priority map bank.
 * Assumes dpmu_defines.svh is on the include path.
 */
`include "dpmu_defines.svh"

package dpmu_pkg;

	// one mapping register: odd code in hi, even code in lo
	typedef struct packed {
		logic [`DPMU_PRIO_W-1:0] hi;
		logic [`DPMU_PRIO_W-1:0] lo;
	} dpmu_pair_s;

	// register index inside the bank
	typedef logic [3:0] dpmu_idx_t;

	// result of decoding one register address
	typedef struct packed {
		logic      hit;
		dpmu_idx_t idx;
	} dpmu_dec_s;

endpackage

// ==== core/dpmu_lookup.sv ====
/*
 * Table lookup: picks the priority field for one DSCP code out of the
 * twelve mapping registers. Purely combinational.
 * Assumes the caller registers the result and handles codes outside
 * 0x22..0x39, for which hit is low and prio is zero.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpmu_defines.svh"

module dpmu_lookup
	import dpmu_pkg::*;
(
	input  wire dpmu_pair_s                tbl [`DPMU_NREG],
	input  wire logic [`DPMU_DSCP_W-1:0]   code,
	output logic      [`DPMU_PRIO_W-1:0]   prio,
	output logic                           hit
);

	logic [`DPMU_DSCP_W-1:0] rel;

	// offset from first code, pair index is rel/2, odd code selects hi
	always_comb begin
		rel  = code - `DPMU_CODE_FIRST;
		hit  = (code >= `DPMU_CODE_FIRST) && (code <= `DPMU_CODE_LAST);
		prio = `DPMU_PRIO_RST;
		if (hit) begin
			if (code[0]) begin
				prio = tbl[rel[4:1]].hi;
			end else begin
				prio = tbl[rel[4:1]].lo;
			end
		end
	end

endmodule

`default_nettype wire

// ==== core/dpmu_bank.sv ====
/*
 * Upper DSCP priority map bank: twelve 8-bit mapping registers for
 * codes 0x22..0x39, a register port, and a registered lookup port for
 * the packet classifier.
 * Assumes one clock, synchronous active-high reset, a master that never
 * raises read and write strobes together, and a classifier that
 * presents the DSCP code already extracted from the IP header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpmu_defines.svh"

module dpmu_bank
	import dpmu_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic [`DPMU_ADDR_W-1:0]   reg_addr,
	input  wire logic [`DPMU_DATA_W-1:0]   reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [`DPMU_DATA_W-1:0]   reg_rdata,
	input  wire logic                      lk_valid,
	input  wire logic [`DPMU_DSCP_W-1:0]   lk_dscp,
	input  wire logic                      lk_ipv6,
	output logic                           res_valid,
	output logic      [`DPMU_PRIO_W-1:0]   res_prio,
	output logic                           res_hit,
	output logic                           res_ipv6
);

	// address to register index, shared by write and read paths
	function automatic dpmu_dec_s dec_addr(input logic [`DPMU_ADDR_W-1:0] a);
		dpmu_dec_s d;
		d.hit = 1'b1;
		d.idx = 4'h0;
		case (a)
			`DPMU_OFS_22_23: d.idx = 4'h0;
			`DPMU_OFS_24_25: d.idx = 4'h1;
			`DPMU_OFS_26_27: d.idx = 4'h2;
			`DPMU_OFS_28_29: d.idx = 4'h3;
			`DPMU_OFS_2A_2B: d.idx = 4'h4;
			`DPMU_OFS_2C_2D: d.idx = 4'h5;
			`DPMU_OFS_2E_2F: d.idx = 4'h6;
			`DPMU_OFS_30_31: d.idx = 4'h7;
			`DPMU_OFS_32_33: d.idx = 4'h8;
			`DPMU_OFS_34_35: d.idx = 4'h9;
			`DPMU_OFS_36_37: d.idx = 4'ha;
			`DPMU_OFS_38_39: d.idx = 4'hb;
			default: d.hit = 1'b0;
		endcase
		return d;
	endfunction

	// register image of one pair, reserved bits forced low
	function automatic logic [`DPMU_DATA_W-1:0] pair_to_byte(input dpmu_pair_s p);
		logic [`DPMU_DATA_W-1:0] b;
		b = `DPMU_RDATA_RST;
		b[`DPMU_HI_MSB:`DPMU_HI_LSB] = p.hi;
		b[`DPMU_LO_MSB:`DPMU_LO_LSB] = p.lo;
		b[`DPMU_RSV_HI] = `DPMU_RSV_VAL;
		b[`DPMU_RSV_LO] = `DPMU_RSV_VAL;
		return b;
	endfunction

	// even code served by a register index
	function automatic logic [`DPMU_DSCP_W-1:0] idx_to_code(input dpmu_idx_t i);
		return `DPMU_CODE_FIRST + {1'b0, i, 1'b0};
	endfunction

	dpmu_pair_s                  tbl_r [`DPMU_NREG];
	dpmu_pair_s                  tbl_nxt;
	dpmu_dec_s                   wr_dec;
	dpmu_dec_s                   rd_dec;
	logic [`DPMU_DATA_W-1:0]     rdata_r;
	logic [`DPMU_DATA_W-1:0]     rdata_nxt;
	logic [`DPMU_PRIO_W-1:0]     lk_prio;
	logic                        lk_hit;
	logic                        res_valid_r;
	logic [`DPMU_PRIO_W-1:0]     res_prio_r;
	logic                        res_hit_r;
	logic                        res_ipv6_r;

	// address decode for both strobes
	assign wr_dec = dec_addr(reg_addr);
	assign rd_dec = dec_addr(reg_addr);

	// write data split into the two live fields only
	always_comb begin
		tbl_nxt.hi = reg_wdata[`DPMU_HI_MSB:`DPMU_HI_LSB];
		tbl_nxt.lo = reg_wdata[`DPMU_LO_MSB:`DPMU_LO_LSB];
	end

	// mapping table storage, one entry per register
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < `DPMU_NREG; i++) begin
				tbl_r[i].hi <= `DPMU_PRIO_RST;
				tbl_r[i].lo <= `DPMU_PRIO_RST;
			end
		end else if (reg_wr && wr_dec.hit) begin
			tbl_r[wr_dec.idx] <= tbl_nxt;
		end
	end

	// read mux: unmapped offsets and idle cycles give zero
	always_comb begin
		rdata_nxt = `DPMU_RDATA_RST;
		if (reg_rd && rd_dec.hit) begin
			rdata_nxt = pair_to_byte(tbl_r[rd_dec.idx]);
		end
	end

	// read data register, valid only in the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_r <= `DPMU_RDATA_RST;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// priority select, same path whatever the ip version
	dpmu_lookup u_lookup (
		.tbl  (tbl_r),
		.code (lk_dscp),
		.prio (lk_prio),
		.hit  (lk_hit)
	);

	// lookup result register, one pulse per request
	always_ff @(posedge mclk) begin
		if (rst) begin
			res_valid_r <= 1'b0;
			res_prio_r  <= `DPMU_PRIO_RST;
			res_hit_r   <= 1'b0;
			res_ipv6_r  <= 1'b0;
		end else begin
			res_valid_r <= lk_valid;
			res_prio_r  <= lk_valid ? lk_prio : `DPMU_PRIO_RST;
			res_hit_r   <= lk_valid && lk_hit;
			res_ipv6_r  <= lk_valid && lk_ipv6;
		end
	end

	// outputs straight from their flops
	assign reg_rdata = rdata_r;
	assign res_valid = res_valid_r;
	assign res_prio  = res_prio_r;
	assign res_hit   = res_hit_r;
	assign res_ipv6  = res_ipv6_r;

	// flattened table, read only by the checks below
	logic [6*`DPMU_NREG-1:0] tbl_flat;
	always_comb begin
		tbl_flat = '0;
		for (int i = 0; i < `DPMU_NREG; i++) begin
			tbl_flat[6*i +: 6] = tbl_r[i];
		end
	end

	// one entry out of a flattened table image
	function automatic dpmu_pair_s flat_entry(input logic [6*`DPMU_NREG-1:0] f, input dpmu_idx_t i);
		return f[6*i +: 6];
	endfunction

	// write of a mapped register
	sequence s_map_wr;
		reg_wr && wr_dec.hit;
	endsequence

	// lookup of the odd code of the register written one cycle before
	sequence s_odd_lk;
		lk_valid && !reg_wr
		&& (lk_dscp == (idx_to_code($past(wr_dec.idx)) | 6'h01));
	endsequence

	// lookup of the even code of the register written one cycle before
	sequence s_even_lk;
		lk_valid && !reg_wr
		&& (lk_dscp == idx_to_code($past(wr_dec.idx)));
	endsequence

	// odd code returns the high field written
	property p_odd_hi;
		@(posedge mclk) disable iff (rst)
		s_map_wr ##1 s_odd_lk |=>
			res_hit && (res_prio == $past(reg_wdata[`DPMU_HI_MSB:`DPMU_HI_LSB], 2));
	endproperty
	a_odd_hi: assert property (p_odd_hi)
		else $error("odd code did not return high field");

	// even code returns the low field written
	property p_even_lo;
		@(posedge mclk) disable iff (rst)
		s_map_wr ##1 s_even_lk |=>
			res_hit && (res_prio == ($past(reg_wdata, 2) & 8'h07));
	endproperty
	a_even_lo: assert property (p_even_lo)
		else $error("even code did not return low field");

	// same code looked up as ipv4 then ipv6 gives the same priority
	sequence s_ver_pair;
		(lk_valid && !reg_wr) ##1
		(lk_valid && (lk_dscp == $past(lk_dscp)) && (lk_ipv6 != $past(lk_ipv6)));
	endsequence

	property p_ver_same;
		@(posedge mclk) disable iff (rst)
		s_ver_pair |=> (res_prio == $past(res_prio)) && (res_hit == $past(res_hit));
	endproperty
	a_ver_same: assert property (p_ver_same)
		else $error("ip version changed the priority");

	// whole table is zero after a reset cycle
	property p_rst_zero;
		@(posedge mclk)
		rst |=> (tbl_flat == '0) && (reg_rdata == `DPMU_RDATA_RST) && !res_valid;
	endproperty
	a_rst_zero: assert property (p_rst_zero)
		else $error("state not cleared by reset");

	// first register serves 0x22 from its low field
	property p_first_reg;
		@(posedge mclk) disable iff (rst)
		(reg_wr && reg_addr == `DPMU_OFS_22_23) ##1
		(lk_valid && !reg_wr && lk_dscp == `DPMU_CODE_FIRST)
		|=> res_prio == ($past(reg_wdata, 2) & 8'h07);
	endproperty
	a_first_reg: assert property (p_first_reg)
		else $error("first register does not serve 0x22");

	// last register serves 0x39 from its high field
	property p_last_reg;
		@(posedge mclk) disable iff (rst)
		(reg_wr && reg_addr == `DPMU_OFS_38_39) ##1
		(lk_valid && !reg_wr && lk_dscp == `DPMU_CODE_LAST)
		|=> res_prio == $past(reg_wdata[`DPMU_HI_MSB:`DPMU_HI_LSB], 2);
	endproperty
	a_last_reg: assert property (p_last_reg)
		else $error("last register does not serve 0x39");

	// out of order register at 0x0350 serves 0x2c
	property p_odd_slot;
		@(posedge mclk) disable iff (rst)
		(reg_wr && reg_addr == `DPMU_OFS_2C_2D) ##1
		(lk_valid && !reg_wr && lk_dscp == 6'h2c)
		|=> res_hit && (res_prio == ($past(reg_wdata, 2) & 8'h07));
	endproperty
	a_odd_slot: assert property (p_odd_slot)
		else $error("0x0350 does not serve 0x2c");

	// reserved bits always read low
	property p_rsv_zero;
		@(posedge mclk) disable iff (rst)
		reg_rd |=> !reg_rdata[`DPMU_RSV_HI] && !reg_rdata[`DPMU_RSV_LO];
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved bit read high");

	// write then read returns the live fields of the written byte
	property p_wr_rd;
		@(posedge mclk) disable iff (rst)
		s_map_wr ##1 (reg_rd && reg_addr == $past(reg_addr))
		|=> reg_rdata == ($past(reg_wdata, 2) & 8'h77);
	endproperty
	a_wr_rd: assert property (p_wr_rd)
		else $error("read back differs from write");

	// read data stands only in the cycle after a read strobe
	property p_rd_window;
		@(posedge mclk) disable iff (rst)
		!reg_rd |=> reg_rdata == `DPMU_RDATA_RST;
	endproperty
	a_rd_window: assert property (p_rd_window)
		else $error("read data outside its cycle");

	// unmapped write leaves the table untouched
	property p_unmapped_wr;
		@(posedge mclk) disable iff (rst)
		reg_wr && !wr_dec.hit |=> $stable(tbl_flat);
	endproperty
	a_unmapped_wr: assert property (p_unmapped_wr)
		else $error("unmapped write changed the table");

	// unmapped read answers zero
	property p_unmapped_rd;
		@(posedge mclk) disable iff (rst)
		reg_rd && !rd_dec.hit |=> reg_rdata == `DPMU_RDATA_RST;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd)
		else $error("unmapped read not zero");

	// codes outside the bank give no hit and priority zero
	property p_out_range;
		@(posedge mclk) disable iff (rst)
		lk_valid && (lk_dscp < `DPMU_CODE_FIRST || lk_dscp > `DPMU_CODE_LAST)
		|=> res_valid && !res_hit && (res_prio == `DPMU_PRIO_RST);
	endproperty
	a_out_range: assert property (p_out_range)
		else $error("out of range code hit the bank");

	// result pulse follows each request by one cycle, ip flag carried
	property p_res_pulse;
		@(posedge mclk) disable iff (rst)
		lk_valid |=> res_valid && (res_ipv6 == $past(lk_ipv6));
	endproperty
	a_res_pulse: assert property (p_res_pulse)
		else $error("lookup result missing");

	// no result without a request
	property p_res_idle;
		@(posedge mclk) disable iff (rst)
		!lk_valid |=> !res_valid && !res_hit && (res_prio == `DPMU_PRIO_RST);
	endproperty
	a_res_idle: assert property (p_res_idle)
		else $error("result without request");

	// a lookup in the write cycle still sees the old value
	property p_wr_same_cycle;
		@(posedge mclk) disable iff (rst)
		s_map_wr and
		(lk_valid && lk_dscp == idx_to_code(wr_dec.idx))
		|=> res_prio == $past(tbl_r[wr_dec.idx].lo);
	endproperty
	a_wr_same_cycle: assert property (p_wr_same_cycle)
		else $error("lookup saw write too early");

	// a mapped write only changes its own entry
	property p_wr_local;
		@(posedge mclk) disable iff (rst)
		s_map_wr ##1 (reg_rd && reg_addr != $past(reg_addr) && rd_dec.hit
		&& !$past(reg_rd))
		|=> reg_rdata == pair_to_byte(flat_entry($past(tbl_flat, 2), $past(rd_dec.idx)));
	endproperty
	a_wr_local: assert property (p_wr_local)
		else $error("write disturbed another entry");

endmodule

`default_nettype wire

// ==== test/dpmu_bank_tb.sv ====
/*
 * Self-checking testbench of the upper DSCP priority map bank.
 * Assumes dpmu_defines.svh on the include path, a 25 MHz mclk and a
 * synchronous active-high reset; the bench drives every port itself.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpmu_defines.svh"

module dpmu_bank_tb;

	logic                      mclk;
	logic                      rst;
	logic [`DPMU_ADDR_W-1:0]   reg_addr;
	logic [`DPMU_DATA_W-1:0]   reg_wdata;
	logic                      reg_wr;
	logic                      reg_rd;
	logic [`DPMU_DATA_W-1:0]   reg_rdata;
	logic                      lk_valid;
	logic [`DPMU_DSCP_W-1:0]   lk_dscp;
	logic                      lk_ipv6;
	logic                      res_valid;
	logic [`DPMU_PRIO_W-1:0]   res_prio;
	logic                      res_hit;
	logic                      res_ipv6;
	int                        err_total;
	int                        n_compared;
	logic [7:0]                mdl [12];
	logic [7:0]                exp_rd;
	logic [5:0]                exp_lk;
	logic                      s_wr;
	logic                      in_rng;
	logic [2:0]                e_prio;
	int                        s_idx;
	int                        k_lk;

	// pair index 0 serves codes 0x22/0x23, index 5 the odd place 0x0350
	localparam logic [15:0] ofs_tab [12] = '{`DPMU_OFS_22_23, `DPMU_OFS_24_25, `DPMU_OFS_26_27,
		`DPMU_OFS_28_29, `DPMU_OFS_2A_2B, `DPMU_OFS_2C_2D, `DPMU_OFS_2E_2F, `DPMU_OFS_30_31,
		`DPMU_OFS_32_33, `DPMU_OFS_34_35, `DPMU_OFS_36_37, `DPMU_OFS_38_39};

	dpmu_bank i_dpmu_bank (
		.mclk      (mclk),
		.rst       (rst),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.lk_valid  (lk_valid),
		.lk_dscp   (lk_dscp),
		.lk_ipv6   (lk_ipv6),
		.res_valid (res_valid),
		.res_prio  (res_prio),
		.res_hit   (res_hit),
		.res_ipv6  (res_ipv6)
	);

	// 40 ns clock
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;

	// pair index of an address, -1 when unmapped
	function automatic int pair_of(input logic [15:0] a);
		int r;
		r = -1;
		for (int k = 0; k < 12; k++) begin
			if (ofs_tab[k] === a) r = k;
		end
		return r;
	endfunction

	// distinct hi and lo fields per register, reserved bits set
	function automatic logic [7:0] pat(input int k);
		return {1'b1, 3'(k + 3), 1'b1, 3'(k)};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] expv);
		n_compared++;
		if (seen !== expv) begin
			err_total++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, expv);
		end
	endtask

	// one bus cycle: strobes, address, data and lookup request together
	task automatic step(input logic w, input logic r, input logic v, input logic [15:0] a,
		input logic [7:0] d, input logic [5:0] c, input logic v6);
		@(posedge mclk);
		reg_wr    <= w;
		reg_rd    <= r;
		lk_valid  <= v;
		reg_addr  <= a;
		reg_wdata <= d;
		lk_dscp   <= c;
		lk_ipv6   <= v6;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		step(1'b1, 1'b0, 1'b0, a, d, 6'h00, 1'b0);
	endtask

	task automatic rd(input logic [15:0] a);
		step(1'b0, 1'b1, 1'b0, a, 8'h00, 6'h00, 1'b0);
	endtask

	task automatic lk(input logic [5:0] c, input logic v6);
		step(1'b0, 1'b0, 1'b1, 16'h0000, 8'h00, c, v6);
	endtask

	task automatic idle();
		step(1'b0, 1'b0, 1'b0, 16'h0000, 8'h00, 6'h00, 1'b0);
		@(posedge mclk);
		@(posedge mclk);
	endtask

	task automatic give_verdict();
		$display("compared %0d, wrong %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// reference model: samples requests at the edge, checks answers 1 ns after that edge
	always @(posedge mclk) begin
		if (rst) begin
			for (int k = 0; k < 12; k++) mdl[k] = 8'h00;
			exp_rd = 8'h00;
			exp_lk = 6'h00;
			s_wr   = 1'b0;
		end else begin
			s_idx  = pair_of(reg_addr);
			s_wr   = reg_wr;
			exp_rd = (reg_rd && s_idx >= 0) ? mdl[s_idx] : 8'h00;
			in_rng = (lk_dscp >= `DPMU_CODE_FIRST) && (lk_dscp <= `DPMU_CODE_LAST);
			k_lk   = in_rng ? (int'(lk_dscp) - 'h22) / 2 : 0;
			e_prio = !in_rng ? 3'h0 : (lk_dscp[0] ? mdl[k_lk][6:4] : mdl[k_lk][2:0]);
			exp_lk = lk_valid ? {1'b1, in_rng, lk_ipv6, e_prio} : 6'h00;
			if (s_wr && s_idx >= 0) mdl[s_idx] = reg_wdata & 8'h77;
			#1;
			check(reg_rdata, exp_rd);
			check({2'b00, res_valid, res_hit, res_ipv6, res_prio}, {2'b00, exp_lk});
		end
	end

	// watchdog well beyond the expected run length
	initial begin
		#(40 * 5000);
		err_total++;
		give_verdict();
	end

	initial begin
		err_total  = 0;
		n_compared = 0;
		rst        = 1'b1;
		reg_addr   = 16'h0000;
		reg_wdata  = 8'h00;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		lk_valid   = 1'b0;
		lk_dscp    = 6'h00;
		lk_ipv6    = 1'b0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		// reset values of every register and every code
		for (int k = 0; k < 12; k++) rd(ofs_tab[k]);
		for (int c = 'h20; c <= 'h3b; c++) lk(c[5:0], c[0]);
		idle();
		$display("test 1 reset values done");
		// back-to-back writes with reserved bits set, unmapped places, read back
		for (int k = 0; k < 12; k++) wr(ofs_tab[k], pat(k));
		wr(16'h0356, 8'hff);
		wr(16'h034f, 8'hff);
		wr(16'h035d, 8'hff);
		for (int k = 0; k < 12; k++) rd(ofs_tab[k]);
		rd(16'h0356);
		rd(16'h035d);
		idle();
		$display("test 2 register map done");
		// every code with both header kinds, boundaries included
		for (int c = 'h20; c <= 'h3b; c++) lk(c[5:0], c[1]);
		for (int c = 'h20; c <= 'h3b; c++) begin
			lk(c[5:0], 1'b0);
			lk(c[5:0], 1'b1);
		end
		step(1'b1, 1'b0, 1'b1, `DPMU_OFS_26_27, 8'h35, 6'h26, 1'b1);
		lk(6'h26, 1'b0);
		lk(6'h27, 1'b1);
		idle();
		$display("test 3 lookups done");
		// single fields of the odd-placed register, then the first and last registers
		wr(`DPMU_OFS_2C_2D, 8'h88);
		rd(`DPMU_OFS_2C_2D);
		lk(6'h2c, 1'b0);
		wr(`DPMU_OFS_2C_2D, 8'h70);
		lk(6'h2d, 1'b1);
		lk(6'h2c, 1'b0);
		wr(`DPMU_OFS_2C_2D, 8'h07);
		rd(`DPMU_OFS_2C_2D);
		lk(6'h2c, 1'b1);
		lk(6'h2d, 1'b0);
		wr(`DPMU_OFS_2C_2D, 8'hc3);
		lk(6'h2c, 1'b0);
		wr(`DPMU_OFS_22_23, 8'h35);
		lk(`DPMU_CODE_FIRST, 1'b0);
		wr(`DPMU_OFS_38_39, 8'hda);
		lk(`DPMU_CODE_LAST, 1'b1);
		wr(`DPMU_OFS_24_25, 8'h11);
		rd(`DPMU_OFS_2C_2D);
		idle();
		$display("test 4 field split done");
		// second reset in mid-run clears every field
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		for (int k = 0; k < 12; k++) rd(ofs_tab[k]);
		for (int c = 'h22; c <= 'h39; c++) lk(c[5:0], c[0]);
		idle();
		$display("test 5 second reset done");
		give_verdict();
	end

endmodule
`default_nettype wire
